// >>> src/irq_ctrl_pkg.sv
// irq_ctrl_pkg: shared constants for the pending-clear and priority block
// assumes a 32-bit Avalon-MM slave with byte addresses and 32 interrupt lines
package irq_ctrl_pkg;

  // interrupt count and field sizes
  localparam int NUM_IRQ = 32;
  localparam int IRQ_NUM_W = 5;
  localparam int PRIO_FIELD_W = 8;
  localparam int PRIO_STORED_W = 2;
  localparam int PRIO_STORED_LSB = 6;
  localparam int FIELDS_PER_REG = 4;
  localparam int NUM_PRIO_REGS = 8;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [7:0] OFF_PENDING_CLEAR = 8'h00;
  localparam logic [7:0] OFF_SENSE_LEVEL = 8'h04;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h08;
  localparam logic [7:0] OFF_EVENT_ENABLE = 8'h0c;
  localparam logic [7:0] OFF_EVENT_CLEAR = 8'h10;
  localparam logic [7:0] OFF_ACTIVE_STATUS = 8'h14;
  localparam logic [7:0] OFF_PRIORITY_BASE = 8'h20;
  localparam logic [7:0] OFF_PRIORITY_LAST = 8'h3c;

  // event status bit positions
  localparam int EVT_NEW_PENDING = 0;
  localparam int EVT_CLEARED = 1;
  localparam int EVT_BITS = 2;

  // reset values and the value read at unmapped addresses
  localparam logic [1:0] PRIO_RESET = 2'h0;
  localparam logic [31:0] SENSE_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  // bus answer phases
  typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} bus_phase_t;

endpackage

// >>> src/irq_pending_clear_and_priority.sv
// irq_pending_clear_and_priority: pending/active latching, pending-clear register,
// priority registers and highest-priority selection for 32 interrupt lines
// assumes the core reports handler entry and return as one-cycle strobes on CLOCK,
// and interrupt lines may come from any domain (they are synchronised here)
module irq_pending_clear_and_priority
  import irq_ctrl_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CLOCK_EN,
  input wire logic [31:0] IRQ_LINE,
  input wire logic HANDLER_ENTER,
  input wire logic [4:0] HANDLER_ENTER_NUM,
  input wire logic HANDLER_RETURN,
  input wire logic [4:0] HANDLER_RETURN_NUM,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [31:0] PENDING,
  output logic [31:0] ACTIVE,
  output logic BEST_VALID,
  output logic [4:0] BEST_NUM,
  output logic [7:0] BEST_PRIORITY,
  output logic EVENT_IRQ
);

  // line synchronisers: three stages, a change counts once stages two and three agree
  logic [31:0] sync1;
  logic [31:0] sync2;
  logic [31:0] sync3;
  logic [31:0] line_level;
  logic [31:0] line_prev;
  logic [31:0] line_rise;

  // register state
  logic [31:0] pending;
  logic [31:0] active;
  logic [31:0] sense_level;
  logic [1:0] prio [NUM_IRQ];
  logic [EVT_BITS-1:0] event_status;
  logic [EVT_BITS-1:0] event_enable;

  // bus state
  bus_phase_t phase;
  logic [31:0] read_word;

  // decoded accesses, valid only in the first cycle of a request
  logic take;
  logic wr_pending_clear;
  logic wr_sense;
  logic wr_enable;
  logic wr_event_clear;
  logic wr_prio;
  logic [2:0] prio_index;
  logic [31:0] clear_mask;

  // per-interrupt next state
  logic [31:0] set_pend;
  logic [31:0] clear_pend;
  logic [31:0] next_pending;
  logic [31:0] next_active;

  // selection result
  logic next_best_valid;
  logic [4:0] next_best_num;
  logic [1:0] next_best_prio;

  // stage one is read only by stage two
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else if (CLOCK_EN) begin
      sync1 <= IRQ_LINE;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // filtered line level: only moves on lines whose last two samples agree
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      line_level <= '0;
      line_prev <= '0;
    end else if (CLOCK_EN) begin
      // agreeing stages load the level, disagreeing ones hold it, so a line can also fall
      line_level <= (line_level & (sync2 ^ sync3)) | (sync3 & ~(sync2 ^ sync3));
      line_prev <= line_level;
    end
  end

  // rise detector idles low like the lines, so leaving reset makes no false edge
  assign line_rise = line_level & ~line_prev;

  // bus decode: a request is taken in its first cycle, answered in the next
  assign take = (AVS_READ | AVS_WRITE) && (phase == BUS_IDLE);
  assign wr_pending_clear = take && AVS_WRITE && (AVS_ADDRESS == OFF_PENDING_CLEAR);
  assign wr_sense = take && AVS_WRITE && (AVS_ADDRESS == OFF_SENSE_LEVEL);
  assign wr_enable = take && AVS_WRITE && (AVS_ADDRESS == OFF_EVENT_ENABLE);
  assign wr_event_clear = take && AVS_WRITE && (AVS_ADDRESS == OFF_EVENT_CLEAR);
  assign wr_prio = take && AVS_WRITE && (AVS_ADDRESS >= OFF_PRIORITY_BASE)
                   && (AVS_ADDRESS <= OFF_PRIORITY_LAST) && (AVS_ADDRESS[1:0] == 2'h0);
  assign prio_index = 3'((AVS_ADDRESS - OFF_PRIORITY_BASE) >> 2);

  // byte enables gate the clear mask so a partial write clears only its lanes
  always_comb begin
    clear_mask = '0;
    for (int b = 0; b < 4; b++) begin
      if (AVS_BYTEENABLE[b]) begin
        clear_mask[b*8 +: 8] = AVS_WRITEDATA[b*8 +: 8];
      end
    end
    if (!wr_pending_clear) begin
      clear_mask = '0;
    end
  end

  // pending and active update per interrupt; detection beats a clear in the same cycle
  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      // level: asserted while not active; pulse: rising edge at any time
      set_pend[i] = sense_level[i] ? (line_level[i] && !active[i]) : line_rise[i];
      // a level line still asserted makes the clear a no-op
      clear_pend[i] = clear_mask[i] && !(sense_level[i] && line_level[i]);
      next_pending[i] = pending[i];
      next_active[i] = active[i];
      if (clear_pend[i]) begin
        next_pending[i] = 1'b0;
      end
      if (HANDLER_ENTER && (HANDLER_ENTER_NUM == IRQ_NUM_W'(i)) && pending[i]) begin
        next_pending[i] = 1'b0;
        next_active[i] = 1'b1;
      end
      if (HANDLER_RETURN && (HANDLER_RETURN_NUM == IRQ_NUM_W'(i))) begin
        next_active[i] = 1'b0;
      end
      // a level line re-pends only while its handler is not active, so entry takes it
      if (set_pend[i] && !(sense_level[i] && next_active[i])) begin
        next_pending[i] = 1'b1;
      end
    end
  end

  // state flops; the clear path never touches active
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pending <= '0;
      active <= '0;
    end else if (CLOCK_EN) begin
      pending <= next_pending;
      active <= next_active;
    end
  end

  // sense register: one selects level-sensitive, zero selects pulse
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sense_level <= SENSE_RESET;
    end else if (CLOCK_EN && wr_sense) begin
      sense_level <= AVS_WRITEDATA;
    end
  end

  // priority storage: two bits per field, word writes only
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        prio[i] <= PRIO_RESET;
      end
    end else if (CLOCK_EN && wr_prio && (AVS_BYTEENABLE == 4'hf)) begin
      for (int lane = 0; lane < FIELDS_PER_REG; lane++) begin
        // field M sits in register M/4, lane M%4; low six bits are dropped
        prio[prio_index * FIELDS_PER_REG + lane] <=
          AVS_WRITEDATA[lane*PRIO_FIELD_W + PRIO_STORED_LSB +: PRIO_STORED_W];
      end
    end
  end

  // event flags: a new pending or a clear-pending hit; the set wins over a clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      event_status <= '0;
    end else if (CLOCK_EN) begin
      event_status <= (event_status & ~(wr_event_clear ? AVS_WRITEDATA[EVT_BITS-1:0] : '0))
                      | {|(clear_pend & pending), |(next_pending & ~pending)};
    end
  end

  // event enable: plain read-write mask over the event flags
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      event_enable <= '0;
    end else if (CLOCK_EN && wr_enable) begin
      event_enable <= AVS_WRITEDATA[EVT_BITS-1:0];
    end
  end

  assign EVENT_IRQ = |(event_status & event_enable);

  // lowest value wins, lowest number breaks a tie; only pending and not active compete
  always_comb begin
    next_best_valid = 1'b0;
    next_best_num = '0;
    next_best_prio = '1;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (pending[i] && !active[i]
          && (!next_best_valid || (prio[i] < next_best_prio))) begin
        next_best_valid = 1'b1;
        next_best_num = IRQ_NUM_W'(i);
        next_best_prio = prio[i];
      end
    end
  end

  // selection registered to keep the 32-way compare off the core's timing path
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      BEST_VALID <= 1'b0;
      BEST_NUM <= '0;
      BEST_PRIORITY <= '0;
    end else if (CLOCK_EN) begin
      BEST_VALID <= next_best_valid;
      BEST_NUM <= next_best_num;
      BEST_PRIORITY <= {next_best_prio, 6'h00};
    end
  end

  // state outputs come straight from the flops
  assign PENDING = pending;
  assign ACTIVE = active;

  // read mux, captured in the take cycle
  always_comb begin
    read_word = READ_UNMAPPED;
    if (AVS_ADDRESS == OFF_PENDING_CLEAR) begin
      read_word = pending;
    end else if (AVS_ADDRESS == OFF_SENSE_LEVEL) begin
      read_word = sense_level;
    end else if (AVS_ADDRESS == OFF_EVENT_STATUS) begin
      read_word = {30'h0, event_status};
    end else if (AVS_ADDRESS == OFF_EVENT_ENABLE) begin
      read_word = {30'h0, event_enable};
    end else if (AVS_ADDRESS == OFF_ACTIVE_STATUS) begin
      read_word = active;
    end else if ((AVS_ADDRESS >= OFF_PRIORITY_BASE) && (AVS_ADDRESS <= OFF_PRIORITY_LAST)
                 && (AVS_ADDRESS[1:0] == 2'h0)) begin
      for (int lane = 0; lane < FIELDS_PER_REG; lane++) begin
        read_word[lane*PRIO_FIELD_W + PRIO_STORED_LSB +: PRIO_STORED_W] =
          prio[prio_index * FIELDS_PER_REG + lane];
      end
    end
  end

  // one wait state: answer comes the cycle after the request is taken
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      phase <= BUS_IDLE;
    end else if (CLOCK_EN) begin
      case (phase)
        BUS_IDLE: begin
          if (take) begin
            phase <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          phase <= BUS_IDLE;
        end
        default: begin
          phase <= BUS_IDLE;
        end
      endcase
    end
  end

  // read data latched at take and held, so it still stands in the answer cycle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      AVS_READDATA <= '0;
    end else if (CLOCK_EN && take) begin
      AVS_READDATA <= AVS_READ ? read_word : '0;
    end
  end

  // waitrequest low only in the answer cycle
  assign AVS_WAITREQUEST = !(phase == BUS_ANSWER);

endmodule

// >>> testbench/irq_pcp_sva.sv
// irq_pcp_sva: port checker for the pending-clear and priority block
// assumes CLOCK_EN is held high while requests run
module irq_pcp_sva
  import irq_ctrl_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [31:0] IRQ_LINE,
  input wire logic HANDLER_ENTER,
  input wire logic HANDLER_RETURN,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [31:0] PENDING,
  input wire logic [31:0] ACTIVE,
  input wire logic BEST_VALID,
  input wire logic [4:0] BEST_NUM,
  input wire logic [7:0] BEST_PRIORITY,
  input wire logic EVENT_IRQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic [2:0] quiet;
  logic clr, rd;
  // lines quiet long enough that no detection is left in the sync chain
  always_ff @(posedge CLOCK) begin
    if (RST || IRQ_LINE != '0) quiet <= 3'h0;
    else if (quiet != 3'h7) quiet <= quiet + 3'h1;
  end
  assign clr = !AVS_WAITREQUEST && AVS_WRITE && AVS_ADDRESS == OFF_PENDING_CLEAR
    && AVS_BYTEENABLE == 4'hf && quiet == 3'h7;
  assign rd = AVS_READ && !AVS_WAITREQUEST;
  wait_one_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low twice");
  answer_a: assert property ($rose(AVS_READ) |=> !AVS_WAITREQUEST)
    else $error("read not answered");
  clear_one_a: assert property (clr |-> (PENDING & AVS_WRITEDATA) == '0)
    else $error("pending not cleared");
  clear_zero_a: assert property (clr && !$past(HANDLER_ENTER)
    |-> (PENDING & ~AVS_WRITEDATA) == ($past(PENDING) & ~AVS_WRITEDATA))
    else $error("zero bit changed pending");
  active_keep_a: assert property (clr && !$past(HANDLER_ENTER) && !$past(HANDLER_RETURN)
    |-> ACTIVE == $past(ACTIVE)) else $error("clear changed active");
  read_pend_a: assert property (rd && AVS_ADDRESS == OFF_PENDING_CLEAR
    |-> AVS_READDATA == $past(PENDING)) else $error("pending readback wrong");
  prio_low_a: assert property (rd && AVS_ADDRESS >= OFF_PRIORITY_BASE
    && AVS_ADDRESS <= OFF_PRIORITY_LAST |-> (AVS_READDATA & 32'h3f3f3f3f) == '0)
    else $error("priority low bits set");
  best_pick_a: assert property (BEST_VALID |-> BEST_PRIORITY[5:0] == 6'h0
    && ((($past(PENDING) & ~$past(ACTIVE)) >> BEST_NUM) & 32'h1) == 32'h1)
    else $error("best not pending");
  reset_zero_a: assert property (disable iff (1'b0) RST |=> PENDING == '0
    && ACTIVE == '0 && !BEST_VALID) else $error("state after reset");
  c_clear: cover property (clr);
  c_best: cover property (BEST_VALID && BEST_NUM == 5'd22);
  c_event: cover property (EVENT_IRQ);
endmodule

bind irq_pending_clear_and_priority irq_pcp_sva chk (.CLOCK(CLOCK), .RST(RST),
  .IRQ_LINE(IRQ_LINE), .HANDLER_ENTER(HANDLER_ENTER), .HANDLER_RETURN(HANDLER_RETURN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .PENDING(PENDING),
  .ACTIVE(ACTIVE), .BEST_VALID(BEST_VALID), .BEST_NUM(BEST_NUM),
  .BEST_PRIORITY(BEST_PRIORITY), .EVENT_IRQ(EVENT_IRQ));

// >>> testbench/irq_src_model.sv
// irq_src_model: peripheral request lines and core handler strobes
// assumes its tasks are called just after a rising edge of clk
module irq_src_model (
  input wire logic clk,
  output logic [31:0] line,
  output logic enter,
  output logic [4:0] enter_num,
  output logic ret,
  output logic [4:0] ret_num
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    line = '0;
    enter = 1'b0;
    enter_num = 5'h0;
    ret = 1'b0;
    ret_num = 5'h0;
  end
  // two cycles wide so the synchroniser cannot miss it while CLOCK_EN is high
  task automatic pulse(input int n);
    line[n] <= 1'b1;
    repeat (2) @(posedge clk);
    line[n] <= 1'b0;
  endtask
  task automatic level(input int n, input logic v);
    line[n] <= v;
  endtask
  // core strobes last exactly one cycle
  task automatic strobe(input logic is_ret, input int n);
    if (is_ret) begin
      ret_num <= n[4:0];
      ret <= 1'b1;
    end else begin
      enter_num <= n[4:0];
      enter <= 1'b1;
    end
    @(posedge clk);
    ret <= 1'b0;
    enter <= 1'b0;
  endtask
endmodule

// >>> testbench/tb_top.sv
// tb_top: register-level bench for the pending-clear and priority block
// assumes the partner model drives lines and handler strobes
module tb_top
  import irq_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] be = 4'hf;
  logic cen = 1'b1;
  logic [31:0] rdata, line, pend, act;
  logic enter, ret, wait_req, best_valid, evt;
  logic [4:0] enter_num, ret_num, best_num;
  logic [7:0] best_prio;
  int n_mismatch = 0;
  int num_checks = 0;
  initial forever #12.5 clk = ~clk;
  irq_src_model src (.clk(clk), .line(line), .enter(enter), .enter_num(enter_num),
    .ret(ret), .ret_num(ret_num));
  irq_pending_clear_and_priority uut (.CLOCK(clk), .RST(rst), .CLOCK_EN(cen),
    .IRQ_LINE(line), .HANDLER_ENTER(enter), .HANDLER_ENTER_NUM(enter_num),
    .HANDLER_RETURN(ret), .HANDLER_RETURN_NUM(ret_num), .AVS_ADDRESS(addr),
    .AVS_READ(rd_req), .AVS_WRITE(wr_req), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .PENDING(pend), .ACTIVE(act),
    .BEST_VALID(best_valid), .BEST_NUM(best_num), .BEST_PRIORITY(best_prio),
    .EVENT_IRQ(evt));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bounded wait so a stuck slave ends the run instead of hanging it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int k;
    addr <= a;
    wdata <= d;
    rd_req <= !w;
    wr_req <= w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wait_req !== 1'b0 && k < 50);
    q = rdata;
    rd_req <= 1'b0;
    wr_req <= 1'b0;
    // one idle edge so the next call never reassigns a strobe in this time step
    @(posedge clk);
    if (k == 50) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  initial begin
    logic [31:0] d;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // every priority field starts at zero; unmapped space reads zero
    for (int k = 0; k < 8; k++) rd_chk(OFF_PRIORITY_BASE + 8'(4 * k), 32'h0);
    rd_chk(8'h18, READ_UNMAPPED);
    for (int k = 0; k < 8; k++) begin
      d = {8'(k << 6), 8'h3f, 8'hff, 8'(~(k << 6))};
      wr(OFF_PRIORITY_BASE + 8'(4 * k), d);
      rd_chk(OFF_PRIORITY_BASE + 8'(4 * k), d & 32'hc0c0c0c0);
    end
    // a narrow write to a priority register is dropped
    be <= 4'h1;
    wr(OFF_PRIORITY_BASE, 32'h0);
    be <= 4'hf;
    rd_chk(OFF_PRIORITY_BASE, 32'h0000c0c0);
    for (int k = 0; k < 8; k++) wr(OFF_PRIORITY_BASE + 8'(4 * k), 32'hffffffff);
    wr(OFF_PRIORITY_BASE + 8'h14, 32'hff40ffff);
    wr(OFF_PRIORITY_BASE + 8'h04, 32'hffff80ff);
    src.pulse(5);
    src.pulse(22);
    repeat (8) @(posedge clk);
    rd_chk(OFF_PENDING_CLEAR, 32'h00400020);
    check({27'h0, best_num}, 32'd22);
    check({31'h0, best_valid}, 32'h1);
    check({24'h0, best_prio}, 32'h40);
    wr(OFF_PRIORITY_BASE + 8'h04, 32'hffff40ff);
    repeat (2) @(posedge clk);
    check({27'h0, best_num}, 32'd5);
    // cleared-event interrupt: raise, mask, clear
    wr(OFF_EVENT_ENABLE, 32'h2);
    check({31'h0, evt}, 32'h0);
    wr(OFF_PENDING_CLEAR, 32'h00400000);
    rd_chk(OFF_PENDING_CLEAR, 32'h00000020);
    check({31'h0, evt}, 32'h1);
    rd_chk(OFF_EVENT_STATUS, 32'h3);
    wr(OFF_EVENT_ENABLE, 32'h0);
    check({31'h0, evt}, 32'h0);
    wr(OFF_EVENT_ENABLE, 32'h2);
    wr(OFF_EVENT_CLEAR, 32'h3);
    check({31'h0, evt}, 32'h0);
    // pulse source: active and pending falls back to active only
    src.strobe(1'b0, 5);
    @(posedge clk);
    check(act, 32'h20);
    src.pulse(5);
    repeat (8) @(posedge clk);
    check(pend, 32'h20);
    wr(OFF_PENDING_CLEAR, 32'h20);
    @(posedge clk);
    check(pend, 32'h0);
    check(act, 32'h20);
    rd_chk(OFF_ACTIVE_STATUS, 32'h20);
    src.strobe(1'b1, 5);
    // level source held high ignores the clear, released it obeys
    wr(OFF_SENSE_LEVEL, 32'h200);
    rd_chk(OFF_SENSE_LEVEL, 32'h200);
    src.level(9, 1'b1);
    repeat (8) @(posedge clk);
    wr(OFF_PENDING_CLEAR, 32'h200);
    rd_chk(OFF_PENDING_CLEAR, 32'h200);
    src.level(9, 1'b0);
    repeat (8) @(posedge clk);
    wr(OFF_PENDING_CLEAR, 32'h200);
    rd_chk(OFF_PENDING_CLEAR, 32'h0);
    // clock enable low freezes the synchroniser, so a pulse in that time is lost
    cen <= 1'b0;
    src.pulse(3);
    repeat (4) @(posedge clk);
    cen <= 1'b1;
    repeat (8) @(posedge clk);
    check(pend, 32'h0);
    stop_test();
  end
endmodule
